// >>> core/pin_sync2.sv
`timescale 1ns/1ns
module pin_sync2 (
  input wire logic core_clk, // Core clock
  input wire logic arst_n, // Async reset, active low
  input wire logic d, // Asynchronous input
  output logic q // Synchronised level
);
  logic meta_r;

  // Two stages reset to the idle-high bus level; only the second stage is read outside
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= 1'b1;
      q <= 1'b1;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// >>> core/smb_rd_pkg.sv
package smb_rd_pkg;
  // Command codes and byte count carried on the bus
  localparam logic [7:0] CMD_SETUP = 8'hba;
  localparam logic [7:0] CMD_READ = 8'hbd;
  localparam logic [7:0] SETUP_COUNT = 8'h04;
  localparam logic [7:0] READ_COUNT = 8'h04;
  // Opcode in the low bits of command byte one
  localparam logic [2:0] OP_READ = 3'h4;
  // Highest valid port number; anything above is reserved
  localparam logic [4:0] PORT_MAX = 5'h05;
  // Field positions inside command byte three
  localparam int CB3_PORT_LSB = 7;
  localparam int CB3_BE_HI = 5;
  localparam int CB3_BE_LO = 2;
  localparam int CB3_ADDR_HI = 1;
  // Byte positions inside a message, counted from the address byte
  localparam logic [3:0] IDX_ADDR = 4'h0;
  localparam logic [3:0] IDX_CODE = 4'h1;
  localparam logic [3:0] IDX_COUNT = 4'h2;
  localparam logic [3:0] IDX_CB1 = 4'h3;
  localparam logic [3:0] IDX_CB2 = 4'h4;
  localparam logic [3:0] IDX_CB3 = 4'h5;
  localparam logic [3:0] IDX_CB4 = 4'h6;
  localparam logic [3:0] IDX_MAX = 4'hf;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Returned byte positions during the read phase
  localparam logic [2:0] TX_COUNT = 3'h0;
  localparam logic [2:0] TX_D1 = 3'h1;
  localparam logic [2:0] TX_D2 = 3'h2;
  localparam logic [2:0] TX_D3 = 3'h3;
  localparam logic [2:0] TX_D4 = 3'h4;
  localparam logic [2:0] TX_PEC = 3'h5;
  localparam logic [7:0] TX_IDLE_BYTE = 8'hff;
  // Packet error code: CRC-8, polynomial x^8+x^2+x+1, cleared at STOP
  localparam logic [7:0] PEC_POLY = 8'h07;
  localparam logic [7:0] PEC_INIT = 8'h00;
  // Reset values of the decoded selection and the read data
  localparam logic [4:0] PORT_RST = 5'h00;
  localparam logic [11:0] ADDR_RST = 12'h000;
  localparam logic [3:0] BE_RST = 4'h0;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_WAIT} link_state_e;
endpackage

// >>> core/smbus_cfg_block_read_decode.sv
// Functional notes
// RQ1: Command byte one low bits 100b means register read request.
// RQ2: Port number is byte two bits 3:0 above byte three bit 7.
// RQ3: Access goes to the selected port 0..5; higher numbers are reserved.
// RQ4: Byte three bits 5:2 enable register bytes 7:0 up to 31:24.
// RQ5: Enabled bytes may be modified, disabled bytes stay unchanged.
// RQ6: Byte four gives address bits 9:2; bits 1:0 are always zero.
// RQ7: Code BDh performs the block read, returning bits 31:24 first.
// RQ8: Setup is block write BAh, count 04h, four command bytes.
// RQ9: Address bits 11:10 come from byte three bits 1:0.
// RQ10: Incorrect sequences are NACKed from the first wrong byte onward.
// RQ11: Extra byte after data four is the PEC; master NACK ends sending.
// RQ12: Host drives reserved command bits as zero.
`timescale 1ns/1ns
module smbus_cfg_block_read_decode
  import smb_rd_pkg::*;
(
  input wire logic core_clk, // Core clock, 250 MHz
  input wire logic arst_n, // Async reset, active low
  input wire logic scl_in, // SMBus clock from the pin
  input wire logic sda_in, // SMBus data from the pin
  output logic sda_out, // SMBus data drive level, always low
  output logic sda_oe, // High while pulling data low
  input wire logic [6:0] own_addr, // Our 7-bit slave address, static
  output logic [4:0] cfg_port, // Selected port
  output logic [11:0] cfg_addr, // Selected register byte address
  output logic [3:0] cfg_be, // Byte enables, bit 3 = bits 31:24
  output logic cfg_valid, // A complete selection is held
  output logic cfg_rd_req, // Read request, held until ack
  input wire logic cfg_rd_ack, // Read data valid pulse
  input wire logic [31:0] cfg_rd_data // Register contents
);
  import smb_rd_pkg::*;

  logic scl_s, sda_s, scl_d, sda_d;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  link_state_e state_r;
  logic [3:0] bit_cnt_r, byte_idx_r;
  logic [7:0] rx_sh_r, tx_sh_r, code_r, crc_r, tx_sel;
  logic [2:0] tx_idx_r;
  logic err_r, go_tx_r, rd_armed_r;
  logic [3:0] port_hi_r;
  logic [31:0] rd_data_r;
  logic byte_ok, addr_match, rx_done, load_tx;
  logic [4:0] port_cand;

  // Pins cross into the core domain before any logic sees them
  pin_sync2 u_sync_scl (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .d(scl_in),
    .q(scl_s)
  );
  pin_sync2 u_sync_sda (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .d(sda_in),
    .q(sda_s)
  );

  // Delayed copies for edge and condition detection
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;
  assign addr_match = (rx_sh_r[7:1] == own_addr);
  assign port_cand = {port_hi_r, rx_sh_r[CB3_PORT_LSB]}; // RQ2
  assign rx_done = (state_r == ST_RX) && scl_fall && (bit_cnt_r == BITS_PER_BYTE)
                   && !bus_start && !bus_stop;
  assign load_tx = !bus_start && !bus_stop && scl_fall
                   && (((state_r == ST_RX_ACK) && go_tx_r) || (state_r == ST_TX_ACK));

  // Judge each received byte; once one fails the rest are refused too
  always_comb begin
    byte_ok = 1'b0;
    case (byte_idx_r)
      IDX_ADDR: byte_ok = addr_match && (!rx_sh_r[0] || rd_armed_r);
      IDX_CODE: byte_ok = (rx_sh_r == CMD_SETUP) || ((rx_sh_r == CMD_READ) && cfg_valid); // RQ8
      IDX_COUNT: byte_ok = (code_r == CMD_SETUP) && (rx_sh_r == SETUP_COUNT); // RQ8
      IDX_CB1: byte_ok = (code_r == CMD_SETUP) && (rx_sh_r[2:0] == OP_READ); // RQ1
      IDX_CB2: byte_ok = (code_r == CMD_SETUP);
      IDX_CB3: byte_ok = (code_r == CMD_SETUP) && (port_cand <= PORT_MAX); // RQ3
      IDX_CB4: byte_ok = (code_r == CMD_SETUP);
      default: byte_ok = 1'b0;
    endcase
    if (err_r) begin
      byte_ok = 1'b0; // RQ10
    end
  end

  // Byte to return for the current read position
  always_comb begin
    case (tx_idx_r)
      TX_COUNT: tx_sel = READ_COUNT;
      TX_D1: tx_sel = rd_data_r[31:24]; // RQ7
      TX_D2: tx_sel = rd_data_r[23:16];
      TX_D3: tx_sel = rd_data_r[15:8];
      TX_D4: tx_sel = rd_data_r[7:0];
      TX_PEC: tx_sel = crc_r; // RQ11
      default: tx_sel = TX_IDLE_BYTE;
    endcase
  end

  // One byte step of the packet error code
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ({x[6:0], 1'b0} ^ PEC_POLY) : {x[6:0], 1'b0};
    end
    return x;
  endfunction

  // Link sequencer: bit shifting, ACK slots and data drive
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      byte_idx_r <= IDX_ADDR;
      rx_sh_r <= 8'h00;
      tx_sh_r <= 8'h00;
      tx_idx_r <= TX_COUNT;
      err_r <= 1'b0;
      go_tx_r <= 1'b0;
      sda_oe <= 1'b0;
    end else if (bus_start) begin
      // Start or repeated start opens a fresh byte sequence
      state_r <= ST_RX;
      bit_cnt_r <= 4'h0;
      byte_idx_r <= IDX_ADDR;
      tx_idx_r <= TX_COUNT;
      err_r <= 1'b0;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      state_r <= ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state_r)
        ST_RX: begin
          if (scl_rise) begin
            rx_sh_r <= {rx_sh_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (rx_done) begin
            bit_cnt_r <= 4'h0;
            if (byte_idx_r == IDX_ADDR && !addr_match) begin
              state_r <= ST_WAIT; // Someone else's address: stay silent
            end else begin
              state_r <= ST_RX_ACK;
              sda_oe <= byte_ok; // RQ10
              err_r <= err_r | ~byte_ok; // RQ10
              go_tx_r <= (byte_idx_r == IDX_ADDR) && rx_sh_r[0] && byte_ok;
              if (byte_idx_r != IDX_MAX) begin
                byte_idx_r <= byte_idx_r + 4'h1;
              end
            end
          end
        end
        ST_RX_ACK: begin
          if (load_tx) begin
            state_r <= ST_TX;
            sda_oe <= ~tx_sel[7];
            tx_sh_r <= {tx_sel[6:0], 1'b0};
            bit_cnt_r <= 4'h1;
          end else if (scl_fall) begin
            state_r <= ST_RX;
            sda_oe <= 1'b0;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_r == BITS_PER_BYTE) begin
              state_r <= ST_TX_ACK;
              sda_oe <= 1'b0; // Release for the master's ACK
            end else begin
              sda_oe <= ~tx_sh_r[7];
              tx_sh_r <= {tx_sh_r[6:0], 1'b0};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              state_r <= ST_WAIT; // RQ11
            end else if (tx_idx_r != 3'h7) begin
              tx_idx_r <= tx_idx_r + 3'h1;
            end
          end else if (load_tx) begin
            state_r <= ST_TX;
            sda_oe <= ~tx_sel[7];
            tx_sh_r <= {tx_sel[6:0], 1'b0};
            bit_cnt_r <= 4'h1;
          end
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // PEC runs over every byte of the message, including both addresses
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      crc_r <= PEC_INIT;
    end else if (bus_stop) begin
      crc_r <= PEC_INIT;
    end else if (rx_done) begin
      crc_r <= crc8(crc_r, rx_sh_r);
    end else if (load_tx && (tx_idx_r < TX_PEC)) begin
      crc_r <= crc8(crc_r, tx_sel); // RQ11
    end
  end

  // Setup decode; port, enables and address bits 11:10 load at byte three, cfg_valid is only set once byte four is good
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      code_r <= 8'h00;
      port_hi_r <= 4'h0;
      cfg_port <= PORT_RST;
      cfg_addr <= ADDR_RST;
      cfg_be <= BE_RST;
      cfg_valid <= 1'b0;
      rd_armed_r <= 1'b0;
    end else begin
      if (bus_stop) begin
        rd_armed_r <= 1'b0; // Read address only honoured after BDh in one message
      end
      if (rx_done && byte_ok) begin
        case (byte_idx_r)
          IDX_CODE: begin
            code_r <= rx_sh_r;
            rd_armed_r <= (rx_sh_r == CMD_READ); // RQ7
            if (rx_sh_r == CMD_SETUP) begin
              cfg_valid <= 1'b0; // Old selection dropped while a new one arrives
            end
          end
          IDX_CB2: port_hi_r <= rx_sh_r[3:0]; // RQ2
          IDX_CB3: begin
            cfg_port <= port_cand; // RQ3
            cfg_be <= rx_sh_r[CB3_BE_HI:CB3_BE_LO]; // RQ4
            cfg_addr[11:10] <= rx_sh_r[CB3_ADDR_HI:0]; // RQ9
          end
          IDX_CB4: begin
            cfg_addr[9:0] <= {rx_sh_r, 2'b00}; // RQ6
            cfg_valid <= 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Register fetch handshake; a new request wins over a same-cycle ack
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_rd_req <= 1'b0;
      rd_data_r <= DATA_RST;
    end else begin
      if (cfg_rd_ack) begin
        cfg_rd_req <= 1'b0;
        // A read takes the word whole and modifies no register byte
        rd_data_r <= cfg_rd_data; // RQ5
      end
      if (rx_done && byte_ok && (byte_idx_r == IDX_CODE) && (rx_sh_r == CMD_READ)) begin
        cfg_rd_req <= 1'b1; // RQ7
      end
    end
  end

  // Open-drain pin: level is always low, only the enable moves
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end
endmodule

// >>> sim/smb_host.sv
`timescale 1ns/1ns
// Bus master; clock idles high between frames
module smb_host (
  input wire logic core_clk, // Core clock
  input wire logic dev_oe, // Device pulls data low
  output logic scl, // Link clock
  output logic sda, // Wired data level
  output logic obs_stb, // One result seen
  output logic [8:0] obs // Read flag, then byte or nack
);
  logic drv_low = 1'b0;
  initial begin
    scl = 1'b1;
    obs_stb = 1'b0;
    obs = 9'h0;
  end
  // Pulled up, so a released line reads high
  assign sda = ~(drv_low | dev_oe);
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic note(input logic [8:0] v);
    obs <= v;
    obs_stb <= 1'b1;
    tick(1);
    obs_stb <= 1'b0;
  endtask
  // Data moves mid low phase, well away from clock edges
  task automatic bit_io(input logic b, output logic s);
    drv_low <= ~b;
    tick(4);
    scl <= 1'b1;
    tick(4);
    s = sda;
    tick(4);
    scl <= 1'b0;
    tick(4);
  endtask
  task automatic start();
    drv_low <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(8);
    drv_low <= 1'b1;
    tick(8);
    scl <= 1'b0;
    tick(4);
  endtask
  task automatic stop();
    drv_low <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(8);
    drv_low <= 1'b0;
    tick(8);
  endtask
  // Sends MSB first, then reports the ack slot
  task automatic wr(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    note({1'b0, 7'h0, s});
  endtask
  task automatic rd(input logic last);
    logic [7:0] v;
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(last, s);
    note({1'b1, v});
  endtask
endmodule

// >>> sim/smb_rd_props.sv
`timescale 1ns/1ns
// Watches the data drive and the decoded selection of the decoder
module smb_rd_props (
  input wire logic core_clk, // Core clock
  input wire logic arst_n, // Async reset
  input wire logic scl_in, // Link clock pin
  input wire logic sda_out, // Data drive level
  input wire logic sda_oe, // Data pulled low
  input wire logic [4:0] cfg_port, // Port
  input wire logic [11:0] cfg_addr, // Byte address
  input wire logic [3:0] cfg_be, // Enables
  input wire logic cfg_valid, // Selection held
  input wire logic cfg_rd_req, // Read request
  input wire logic cfg_rd_ack // Data valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  open_drain_a: assert property (sda_out == 1'b0) else $error("data high");
  addr_align_a: assert property (cfg_addr[1:0] == 2'h0) else $error("unaligned");
  port_range_a: assert property (cfg_valid |-> cfg_port <= 5'h05) else $error("port");
  sel_stable_a: assert property (cfg_valid && $past(cfg_valid) |->
    $stable({cfg_port, cfg_addr, cfg_be})) else $error("selection moved");
  req_hold_a: assert property (cfg_rd_req && !cfg_rd_ack |=> cfg_rd_req)
    else $error("request dropped");
  req_drop_a: assert property ($fell(cfg_rd_req) |-> $past(cfg_rd_ack))
    else $error("request cleared early");
  req_valid_a: assert property ($rose(cfg_rd_req) |-> cfg_valid) else $error("bad read");
  drive_low_a: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("drive in high phase");
  ack_hold_a: assert property ($rose(sda_oe) |-> sda_oe[*8]) else $error("short drive");
endmodule

bind smbus_cfg_block_read_decode smb_rd_props i_props (.core_clk(core_clk), .arst_n(arst_n),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .cfg_port(cfg_port),
  .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_valid(cfg_valid), .cfg_rd_req(cfg_rd_req),
  .cfg_rd_ack(cfg_rd_ack));

// >>> sim/smbus_cfg_block_read_decode_tb.sv
`timescale 1ns/1ns
module smbus_cfg_block_read_decode_tb;
  import smb_rd_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cfg_rd_ack = 1'b0;
  logic [31:0] cfg_rd_data = 32'h0;
  logic [6:0] own_addr = 7'h3a;
  logic scl, sda, sda_out, sda_oe, cfg_valid, cfg_rd_req, obs_stb;
  logic valid_q = 1'b0;
  logic [4:0] cfg_port;
  logic [11:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [8:0] obs;
  logic [8:0] exp_obs[$];
  logic [20:0] exp_sel[$];
  int n_errors = 0;
  int comparisons = 0;
  always #2 core_clk = ~core_clk;
  smbus_cfg_block_read_decode i_dut (.core_clk(core_clk), .arst_n(arst_n), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .own_addr(own_addr),
    .cfg_port(cfg_port), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_valid(cfg_valid),
    .cfg_rd_req(cfg_rd_req), .cfg_rd_ack(cfg_rd_ack), .cfg_rd_data(cfg_rd_data));
  smb_host i_host (.core_clk(core_clk), .dev_oe(sda_oe), .scl(scl), .sda(sda),
    .obs_stb(obs_stb), .obs(obs));
  // Register side answers each request with one pulse
  always @(posedge core_clk) cfg_rd_ack <= cfg_rd_req && !cfg_rd_ack;
  // Oldest note against each bus result and each new selection
  always @(posedge core_clk) begin
    valid_q <= cfg_valid;
    if (obs_stb) begin
      comparisons++;
      if (exp_obs.size() == 0 || exp_obs.pop_front() !== obs) begin
        n_errors++;
        $display("ERROR %0t bus result %h", $time, obs);
      end
    end
    if (cfg_valid && !valid_q) begin
      comparisons++;
      if (exp_sel.size() == 0 || exp_sel.pop_front() !== {cfg_port, cfg_addr, cfg_be}) begin
        n_errors++;
        $display("ERROR %0t selection", $time);
      end
    end
  end
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    repeat (8) x = x[7] ? {x[6:0], 1'b0} ^ PEC_POLY : {x[6:0], 1'b0};
    return x;
  endfunction
  // Acks expected before the first wrong byte, nacks from it onward
  task automatic send(input logic [7:0] m[$], input int bad);
    foreach (m[i]) begin
      exp_obs.push_back({1'b0, 7'h0, i >= bad});
      i_host.wr(m[i]);
    end
  endtask
  task automatic setup(input logic [4:0] p, input logic [7:0] code, cnt, c1, input int bad);
    logic [7:0] c3, c4;
    c3 = {p[0], 1'b0, 4'($urandom), 2'($urandom)};
    c4 = 8'($urandom);
    if (bad > 6) exp_sel.push_back({p, c3[1:0], c4, 2'b00, c3[5:2]});
    i_host.start();
    send('{{own_addr, 1'b0}, code, cnt, c1, {4'h0, p[4:1]}, c3, c4}, bad);
    i_host.stop();
  endtask
  // Read with repeated start; data, then the check byte, then master nack
  task automatic read_back();
    logic [7:0] b[$];
    logic [31:0] d;
    logic [7:0] pec;
    d = $urandom;
    cfg_rd_data <= d;
    i_host.start();
    send('{{own_addr, 1'b0}, CMD_READ}, 9);
    i_host.start();
    send('{{own_addr, 1'b1}}, 9);
    b = '{{own_addr, 1'b0}, CMD_READ, {own_addr, 1'b1}, READ_COUNT, d[31:24], d[23:16],
      d[15:8], d[7:0]};
    pec = PEC_INIT;
    foreach (b[i]) pec = crc8(pec, b[i]);
    b.push_back(pec);
    for (int i = 3; i < 9; i++) begin
      exp_obs.push_back({1'b1, b[i]});
      i_host.rd(i == 8);
    end
    i_host.stop();
  endtask
  task automatic give_verdict();
    if (exp_obs.size() != 0 || exp_sel.size() != 0) n_errors++;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Runs far longer than the whole sequence should take
  initial begin
    repeat (80000) @(posedge core_clk);
    n_errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(53418));
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    i_host.start();
    send('{{own_addr, 1'b0}, CMD_READ}, 1);
    i_host.stop();
    i_host.start();
    send('{{~own_addr, 1'b0}}, 0);
    i_host.stop();
    // Read address with no block read code earlier in the message
    i_host.start();
    send('{{own_addr, 1'b1}}, 0);
    i_host.stop();
    setup(5'h1, 8'hbe, SETUP_COUNT, 8'h04, 1);
    setup(5'h1, CMD_SETUP, 8'h05, 8'h04, 2);
    setup(5'h1, CMD_SETUP, SETUP_COUNT, 8'h03, 3);
    // Reserved port number is refused at command byte three
    setup(5'(6 + $urandom % 26), CMD_SETUP, SETUP_COUNT, 8'h04, 5);
    // Every valid port, reserved bits kept zero
    for (int p = 0; p < 6; p++) begin
      setup(5'(p), CMD_SETUP, SETUP_COUNT, 8'h04, 7);
      read_back();
    end
    // Any byte after the block read code is refused
    i_host.start();
    send('{{own_addr, 1'b0}, CMD_READ, READ_COUNT}, 2);
    i_host.stop();
    read_back();
    // Mid-run reset must drop the held selection
    arst_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    i_host.start();
    send('{{own_addr, 1'b0}, CMD_READ}, 1);
    i_host.stop();
    repeat (50) @(posedge core_clk);
    give_verdict();
  end
endmodule
